// File: dv/tb_vbus_power_path_control.sv
// Purpose: Self-checking bench for the bus power path block
// Assumes: MS_CYCLES 10 and RECOVERY_MS 2 so timers stay short
// Notes: Nominal 200 with zero shifts gives 190..210; the profile test steps to 150 (142..157)
`timescale 1ns/1ns
module tb_vbus_power_path_control;
    logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, oe, irq, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [2:0] attach = 3'h0;
    logic [9:0] level = 10'h0c8, sense, nominal = 10'h0c8;
    logic clk_en = 1'b1, prof = 1'b0, sup_uv = 1'b1, sup_ov = 1'b1;
    logic win_nvm = 1'b1, uv_nvm = 1'b0, ov_nvm = 1'b1, dis_nvm = 1'b1;
    logic uvlo, dis, ext_n, fault, refused, n_o;
    int miscompares = 0, checked = 0, cyc = 0, n;
    vbus_power_path_control #(.MS_CYCLES(10), .RECOVERY_MS(2)) dut (.core_clk(core_clk),
        .nrst(nrst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .attach_state(attach),
        .nominal_code(nominal), .profile_change(prof), .bus_voltage_sense_input(sense),
        .bus_above_uvlo(uvlo), .supply_above_uv(sup_uv), .supply_below_ov(sup_ov),
        .nvm_shift_hi(4'h0), .nvm_shift_lo(4'h0), .nvm_t_pdo(11'h003), .nvm_t_zero(11'h002),
        .nvm_window_en(win_nvm), .nvm_uv_en(uv_nvm), .nvm_ov_en(ov_nvm), .nvm_disch_en(dis_nvm),
        .source_power_enable_n_o(n_o), .source_power_enable_n_oe(oe),
        .internal_discharge_on(dis), .external_discharge_control_n(ext_n),
        .fault_recovery_active(fault), .connect_refused(refused));
    vbus_sink_model sink (.core_clk(core_clk), .disch_on(dis), .switch_on(oe), .level(level),
        .sense(sense), .above_uvlo(uvlo));
    // Free running clock, 4 ns period
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            test_done();
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One single transfer, held until hready is seen high at each phase
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask : bus
    // Bounded wait for a design output to reach a level
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_for
    task t_regs;
        bus(1'b0, 32'h00, 32'h0); check("ctrl", rd, 32'h5);
        check("hresp", hresp, 1'b0);
        bus(1'b0, 32'h08, 32'h0); check("tpdo", rd, 32'h3);
        bus(1'b0, 32'h1c, 32'h0); check("unmapped", rd, 32'h0);
        bus(1'b1, 32'h04, 32'h0305); bus(1'b0, 32'h04, 32'h0); check("shift", rd, 32'h0305);
        bus(1'b1, 32'h04, 32'h0); bus(1'b1, 32'h10, 32'h0);
        bus(1'b0, 32'h10, 32'h0); check("disch_en", rd[5], 1'b1);
    endtask : t_regs
    task t_attach;
        bus(1'b1, 32'h18, 32'h7);
        attach <= 3'h1;
        wait_for(oe, 1'b1, 20); check("oe_on", oe, 1'b1);
        check("pin_low", n_o, 1'b0);
        bus(1'b0, 32'h10, 32'h0); check("blank", rd[4:3], 2'h1);
        wait_for(irq, 1'b1, 100); check("blank_len", n > 14 && n < 40, 1'b1);
        bus(1'b0, 32'h14, 32'h0); check("blank_done", rd, 32'h4);
        bus(1'b1, 32'h14, 32'h7); @(posedge core_clk); check("irq_clr", irq, 1'b0);
    endtask : t_attach
    task t_profile;
        nominal <= 10'h096; level <= 10'h096; prof <= 1'b1; // Step down to 150
        @(posedge core_clk);
        prof <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("lower_disch", dis, 1'b1); check("oe_blank", oe, 1'b1);
        wait_for(irq, 1'b1, 100); check("prof_blank", n > 10, 1'b1);
        check("disch_end", dis, 1'b0); check("prof_on", oe && !fault, 1'b1);
        bus(1'b1, 32'h14, 32'h7);
    endtask : t_profile
    task t_fault;
        level <= 10'h09e; // One code above the high limit of 157
        wait_for(fault, 1'b1, 20); check("fault", fault, 1'b1);
        @(posedge core_clk); // Discharge flop follows the fault flop by one edge
        check("oe_off", oe, 1'b0); check("disch", dis, 1'b1);
        check("ext_disch", ext_n, 1'b0);
        clk_en <= 1'b0;
        repeat (30) @(posedge core_clk);
        check("frozen", fault && dis, 1'b1);
        clk_en <= 1'b1;
        attach <= 3'h0;
        wait_for(fault, 1'b0, 40); check("recover", n > 10, 1'b1);
        bus(1'b1, 32'h14, 32'h7);
    endtask : t_fault
    task t_refuse;
        level <= 10'h08d; // One code below the low limit of 142
        repeat (30) @(posedge core_clk);
        attach <= 3'h2;
        repeat (6) @(posedge core_clk);
        check("refused", refused, 1'b1); check("oe_held", oe, 1'b0);
        bus(1'b0, 32'h14, 32'h0); check("refuse_irq", rd[0], 1'b1);
        level <= 10'h096; sup_ov <= 1'b0; attach <= 3'h0;
        repeat (30) @(posedge core_clk);
        check("refuse_clr", refused, 1'b0);
        attach <= 3'h3;
        repeat (6) @(posedge core_clk);
        check("ov_refused", refused, 1'b1); check("ov_held", oe, 1'b0);
        attach <= 3'h0; sup_ov <= 1'b1;
    endtask : t_refuse
    task test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_regs();
        t_attach();
        t_profile();
        t_fault();
        t_refuse();
        test_done();
    end
endmodule : tb_vbus_power_path_control

// File: dv/vbus_sink_model.sv
// Purpose: Far side model, external switch plus attached sink on the bus sense node
// Assumes: Level set by the bench is the source rail the switch would pass
// Notes: Discharge pulls the open node to zero, one cycle lag like a real node
`timescale 1ns/1ns
module vbus_sink_model (
    // Clock and discharge path
    input wire logic core_clk,
    input wire logic disch_on,
    input wire logic switch_on,
    // Commanded rail and sensed node
    input wire logic [9:0] level,
    output logic [9:0] sense,
    output logic above_uvlo
);
    // A closed switch holds the node at the rail; discharge only wins once it opens
    always_ff @(posedge core_clk) begin
        sense <= (disch_on && !switch_on) ? 10'h000 : level;
    end
    assign above_uvlo = sense > 10'h032; // Fixed low level, enough for this bench
endmodule : vbus_sink_model

// File: pkg/vbus_cfg_if.sv
// Purpose: Configuration and status between register file and power path core
// Assumes: One clock domain
// Notes: evt carries one-cycle event pulses
`timescale 1ns/1ns
interface vbus_cfg_if;
    logic win_en;
    logic uv_en;
    logic ov_en;
    logic disch_en;
    logic [3:0] shift_hi;
    logic [3:0] shift_lo;
    logic [10:0] t_pdo;
    logic [10:0] t_zero;
    logic src_on;
    logic disch_on;
    logic in_window;
    logic [1:0] st;
    logic [2:0] evt;
    modport regs (output win_en, uv_en, ov_en, disch_en, shift_hi, shift_lo, t_pdo, t_zero,
        input src_on, disch_on, in_window, st, evt);
    modport core (input win_en, uv_en, ov_en, disch_en, shift_hi, shift_lo, t_pdo, t_zero,
        output src_on, disch_on, in_window, st, evt);
endinterface : vbus_cfg_if

// File: pkg/vbus_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the bus power path block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one word per register
// Notes: Times are in milliseconds unless named otherwise
`ifndef VBUS_DEFS_SVH
`define VBUS_DEFS_SVH
`define VB_BASE_PCT 8'h05
`define VB_PCT_DEN 8'h64
`define VB_SHIFT_HI_RST 4'ha
`define VB_SHIFT_LO_RST 4'ha
`define VB_T_PDO_RST 11'h118
`define VB_T_ZERO_RST 11'h0a8
`define VB_RECOVERY_MS 40
`define VB_CLK_NS 4
`define VB_MS_NS 1000000
`define VB_IDX_CTRL 3'h0
`define VB_IDX_SHIFT 3'h1
`define VB_IDX_TPDO 3'h2
`define VB_IDX_TZERO 3'h3
`define VB_IDX_STATUS 3'h4
`define VB_IDX_IRQ_STAT 3'h5
`define VB_IDX_IRQ_MASK 3'h6
`define VB_CTRL_RST 3'h7
`define VB_SHIFT_LO_POS 8
`define VB_IRQ_REFUSE 0
`define VB_IRQ_FAULT 1
`define VB_IRQ_BLANK 2
`endif

// File: pkg/vbus_pkg.sv
// Purpose: Types shared by the bus power path block
// Assumes: Attach state codes come from the attach state machine
// Notes: Codes 5..7 of the attach state count as unattached
package vbus_pkg;
    typedef enum logic [2:0] {
        AT_UNATTACHED = 3'h0,
        AT_SOURCE = 3'h1,
        AT_UNORIENTED_DEBUG = 3'h2,
        AT_ORIENTED_DEBUG = 3'h3,
        AT_FAULT = 3'h4
    } attach_state_t;
    typedef enum logic [1:0] {
        PP_OFF = 2'h0,
        PP_BLANK = 2'h1,
        PP_ON = 2'h2,
        PP_FAULT = 2'h3
    } pp_state_t;
endpackage : vbus_pkg

// File: verilog/vbus_ahb_regs.sv
// Purpose: AHB-Lite register file, startup load and interrupt
// Assumes: Zero wait states, word accesses only
// Notes: Discharge enable has no write path
`timescale 1ns/1ns
`include "vbus_defs.svh"
module vbus_ahb_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    // Startup values
    input wire logic [3:0] nvm_shift_hi,
    input wire logic [3:0] nvm_shift_lo,
    input wire logic [10:0] nvm_t_pdo,
    input wire logic [10:0] nvm_t_zero,
    input wire logic [2:0] nvm_ctrl,
    input wire logic nvm_disch_en,
    // Core side
    vbus_cfg_if.regs cfg
);
    logic wr_pend_r;
    logic [2:0] wr_idx_r;
    logic load_r;
    logic [2:0] ctrl_r;
    logic [3:0] sh_hi_r;
    logic [3:0] sh_lo_r;
    logic [10:0] t_pdo_r;
    logic [10:0] t_zero_r;
    logic disch_en_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;

    // Address decode
    wire logic take = hsel & htrans[1] & hready;
    wire logic [2:0] idx = haddr[4:2];
    wire logic in_map = (haddr[31:5] == 27'h0) & (idx != 3'h7);
    wire logic [31:0] status_w = {26'h0, cfg.disch_en, cfg.st, cfg.in_window,
        cfg.disch_on, cfg.src_on};
    wire logic [31:0] rd_w = !in_map ? 32'h0 :
        (idx == `VB_IDX_CTRL) ? {29'h0, ctrl_r} :
        (idx == `VB_IDX_SHIFT) ? {20'h0, sh_lo_r, 4'h0, sh_hi_r} :
        (idx == `VB_IDX_TPDO) ? {21'h0, t_pdo_r} :
        (idx == `VB_IDX_TZERO) ? {21'h0, t_zero_r} :
        (idx == `VB_IDX_STATUS) ? status_w :
        (idx == `VB_IDX_IRQ_STAT) ? {29'h0, irq_stat_r} : {29'h0, irq_mask_r};
    wire logic wr = wr_pend_r & ~load_r;
    wire logic [2:0] clr_w = (wr && wr_idx_r == `VB_IDX_IRQ_STAT) ? hwdata[2:0] : 3'h0;
    // Set wins over a write-one clear in the same cycle
    wire logic [2:0] stat_nxt = (irq_stat_r & ~clr_w) | cfg.evt;

    // Bus phases and read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 3'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend_r <= take & hwrite & in_map;
            wr_idx_r <= idx;
            hrdata <= (take && !hwrite) ? rd_w : 32'h0;
            hreadyout <= 1'b1;
        end
    end

    // Startup load after every reset, then software writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_r <= 1'b1;
            ctrl_r <= `VB_CTRL_RST;
            sh_hi_r <= `VB_SHIFT_HI_RST;
            sh_lo_r <= `VB_SHIFT_LO_RST;
            t_pdo_r <= `VB_T_PDO_RST;
            t_zero_r <= `VB_T_ZERO_RST;
            disch_en_r <= 1'b1;
            irq_mask_r <= 3'h0;
        end else if (clk_en) begin
            load_r <= 1'b0;
            if (load_r) begin
                ctrl_r <= nvm_ctrl;
                sh_hi_r <= nvm_shift_hi;
                sh_lo_r <= nvm_shift_lo;
                t_pdo_r <= nvm_t_pdo;
                t_zero_r <= nvm_t_zero;
                disch_en_r <= nvm_disch_en;
            end else if (wr) begin
                unique case (wr_idx_r)
                    `VB_IDX_CTRL: ctrl_r <= hwdata[2:0];
                    `VB_IDX_SHIFT: begin
                        sh_hi_r <= hwdata[3:0];
                        sh_lo_r <= hwdata[`VB_SHIFT_LO_POS +: 4];
                    end
                    `VB_IDX_TPDO: t_pdo_r <= hwdata[10:0];
                    `VB_IDX_TZERO: t_zero_r <= hwdata[10:0];
                    `VB_IDX_IRQ_MASK: irq_mask_r <= hwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // Sticky events and level interrupt
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= 3'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat_r <= stat_nxt;
            irq <= |(stat_nxt & irq_mask_r);
        end
    end

    assign cfg.win_en = ctrl_r[0];
    assign cfg.uv_en = ctrl_r[1];
    assign cfg.ov_en = ctrl_r[2];
    assign cfg.shift_hi = sh_hi_r;
    assign cfg.shift_lo = sh_lo_r;
    assign cfg.t_pdo = t_pdo_r;
    assign cfg.t_zero = t_zero_r;
    assign cfg.disch_en = disch_en_r;
endmodule : vbus_ahb_regs

// File: verilog/vbus_power_path_control.sv
// Purpose: Bus voltage supervision, source enable and discharge control
// Assumes: Sense and comparator inputs synchronous to core_clk
// Notes: Millisecond timers run off a free prescaler, so
//   a loaded time is accurate to within one millisecond
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "vbus_defs.svh"
module vbus_power_path_control #(
    parameter int MS_CYCLES = `VB_MS_NS / `VB_CLK_NS,
    parameter int RECOVERY_MS = `VB_RECOVERY_MS
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    // Attach machine and contract
    input wire logic [2:0] attach_state,
    input wire logic [9:0] nominal_code,
    input wire logic profile_change,
    // Analog comparators and sense code
    input wire logic [9:0] bus_voltage_sense_input,
    input wire logic bus_above_uvlo,
    input wire logic supply_above_uv,
    input wire logic supply_below_ov,
    // Startup configuration
    input wire logic [3:0] nvm_shift_hi,
    input wire logic [3:0] nvm_shift_lo,
    input wire logic [10:0] nvm_t_pdo,
    input wire logic [10:0] nvm_t_zero,
    input wire logic nvm_window_en,
    input wire logic nvm_uv_en,
    input wire logic nvm_ov_en,
    input wire logic nvm_disch_en,
    // Power path pins and status
    output logic source_power_enable_n_o,
    output logic source_power_enable_n_oe,
    output logic internal_discharge_on,
    output logic external_discharge_control_n,
    output logic fault_recovery_active,
    output logic connect_refused
);
    logic rst_meta_r;
    logic rst_n;
    logic [9:0] vsense_r;
    logic [9:0] nom_r;
    logic [9:0] target_r;
    logic [2:0] attach_r;
    logic att_prev_r;
    logic prof_r;
    logic bus_uvlo_r;
    logic sup_uv_r;
    logic sup_ov_r;
    logic [17:0] pre_r;
    logic [10:0] blank_cnt_r;
    logic [10:0] disch_cnt_r;
    logic [10:0] rec_cnt_r;
    logic disch_prof_r;
    logic [2:0] evt_r;
    vbus_pkg::pp_state_t st_r;
    vbus_pkg::pp_state_t st_nxt;
    logic [10:0] limit_hi;
    logic [9:0] limit_lo;

    vbus_cfg_if cfg ();

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    vbus_ahb_regs u_regs (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .irq(irq),
        .nvm_shift_hi(nvm_shift_hi),
        .nvm_shift_lo(nvm_shift_lo),
        .nvm_t_pdo(nvm_t_pdo),
        .nvm_t_zero(nvm_t_zero),
        .nvm_ctrl({nvm_ov_en, nvm_uv_en, nvm_window_en}),
        .nvm_disch_en(nvm_disch_en),
        .cfg(cfg.regs)
    );

    vbus_window_calc u_calc (
        .nominal(nom_r),
        .shift_hi(cfg.shift_hi),
        .shift_lo(cfg.shift_lo),
        .limit_hi(limit_hi),
        .limit_lo(limit_lo)
    );

    // Attach decode, ahead of the flops that read it
    wire logic attached_ok = (attach_r == vbus_pkg::AT_SOURCE) |
        (attach_r == vbus_pkg::AT_UNORIENTED_DEBUG) |
        (attach_r == vbus_pkg::AT_ORIENTED_DEBUG);
    wire logic att_fault = attach_r == vbus_pkg::AT_FAULT;
    wire logic attach_evt = attached_ok & ~att_prev_r;
    wire logic att_fall = att_prev_r & ~attached_ok & ~att_fault;

    // Sample every sense and control input once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vsense_r <= 10'h0;
            nom_r <= 10'h0;
            attach_r <= 3'h0;
            att_prev_r <= 1'b0;
            prof_r <= 1'b0;
            bus_uvlo_r <= 1'b0;
            sup_uv_r <= 1'b0;
            sup_ov_r <= 1'b0;
        end else if (clk_en) begin
            vsense_r <= bus_voltage_sense_input;
            nom_r <= nominal_code;
            attach_r <= attach_state;
            att_prev_r <= attached_ok;
            prof_r <= profile_change;
            bus_uvlo_r <= bus_above_uvlo;
            sup_uv_r <= supply_above_uv;
            sup_ov_r <= supply_below_ov;
        end
    end

    // Window and supply checks
    wire logic win_ok = (vsense_r >= limit_lo) & (11'(vsense_r) <= limit_hi);
    wire logic in_window = cfg.win_en ? win_ok : bus_uvlo_r;
    // Supply only gates the off-to-on step; the bus carries it after
    wire logic supply_ok = (~cfg.uv_en | sup_uv_r) & (~cfg.ov_en | sup_ov_r);
    wire logic tick = pre_r == 18'(MS_CYCLES - 1);

    // Power path state machine
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            vbus_pkg::PP_OFF: begin
                if (attach_evt && in_window && supply_ok)
                    st_nxt = vbus_pkg::PP_BLANK;
            end
            vbus_pkg::PP_BLANK: begin
                if (!attached_ok)
                    st_nxt = vbus_pkg::PP_OFF;
                else if (!prof_r && blank_cnt_r == 11'h0)
                    st_nxt = vbus_pkg::PP_ON;
            end
            vbus_pkg::PP_ON: begin
                if (!attached_ok)
                    st_nxt = vbus_pkg::PP_OFF;
                // Profile change wins: the window has already moved to the new nominal
                else if (prof_r)
                    st_nxt = vbus_pkg::PP_BLANK;
                else if (!in_window)
                    st_nxt = vbus_pkg::PP_FAULT;
            end
            vbus_pkg::PP_FAULT: begin
                if (rec_cnt_r == 11'h0 && !att_fault)
                    st_nxt = vbus_pkg::PP_OFF;
            end
        endcase
        if (att_fault && st_r != vbus_pkg::PP_FAULT)
            st_nxt = vbus_pkg::PP_FAULT;
    end

    // Transition events
    wire logic refuse = (st_r == vbus_pkg::PP_OFF) & attach_evt &
        (st_nxt == vbus_pkg::PP_OFF);
    wire logic enter_fault = (st_nxt == vbus_pkg::PP_FAULT) & (st_r != vbus_pkg::PP_FAULT);
    wire logic blank_ld = (st_nxt == vbus_pkg::PP_BLANK) &
        ((st_r != vbus_pkg::PP_BLANK) | prof_r);
    wire logic prof_lower = blank_ld & (st_r != vbus_pkg::PP_OFF) & (nom_r < target_r);
    wire logic blank_done = (st_r == vbus_pkg::PP_BLANK) & (st_nxt == vbus_pkg::PP_ON);
    wire logic disch_on = cfg.disch_en & (disch_cnt_r != 11'h0);
    wire logic drive_on = (st_nxt == vbus_pkg::PP_BLANK) | (st_nxt == vbus_pkg::PP_ON);

    // State, prescaler and retarget
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= vbus_pkg::PP_OFF;
            pre_r <= 18'h0;
            target_r <= 10'h0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            pre_r <= tick ? 18'h0 : pre_r + 18'h1;
            if (blank_ld)
                target_r <= nom_r;
        end
    end

    // Blanking and recovery timers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blank_cnt_r <= 11'h0;
            rec_cnt_r <= 11'h0;
        end else if (clk_en) begin
            if (blank_ld)
                blank_cnt_r <= cfg.t_pdo;
            else if (tick && blank_cnt_r != 11'h0)
                blank_cnt_r <= blank_cnt_r - 11'h1;
            if (enter_fault)
                rec_cnt_r <= 11'(RECOVERY_MS);
            else if (tick && rec_cnt_r != 11'h0)
                rec_cnt_r <= rec_cnt_r - 11'h1;
        end
    end

    // Discharge timer; a zero-volt load outranks a profile load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            disch_cnt_r <= 11'h0;
            disch_prof_r <= 1'b0;
        end else if (clk_en) begin
            if (enter_fault || att_fall) begin
                disch_cnt_r <= cfg.t_zero;
                disch_prof_r <= 1'b0;
            end else if (prof_lower) begin
                disch_cnt_r <= cfg.t_pdo;
                disch_prof_r <= 1'b1;
            end else if (blank_done && disch_prof_r) begin
                disch_cnt_r <= 11'h0;
                disch_prof_r <= 1'b0;
            end else if (tick && disch_cnt_r != 11'h0) begin
                disch_cnt_r <= disch_cnt_r - 11'h1;
            end
        end
    end

    // Output flops; open drain drives low only when enabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            source_power_enable_n_o <= 1'b0;
            source_power_enable_n_oe <= 1'b0;
            internal_discharge_on <= 1'b0;
            external_discharge_control_n <= 1'b1;
            fault_recovery_active <= 1'b0;
            connect_refused <= 1'b0;
            evt_r <= 3'h0;
        end else if (clk_en) begin
            source_power_enable_n_o <= 1'b0;
            source_power_enable_n_oe <= drive_on;
            internal_discharge_on <= disch_on;
            external_discharge_control_n <= ~disch_on;
            fault_recovery_active <= st_nxt == vbus_pkg::PP_FAULT;
            if (refuse)
                connect_refused <= 1'b1;
            else if (att_fall || blank_ld)
                connect_refused <= 1'b0;
            evt_r[`VB_IRQ_REFUSE] <= refuse;
            evt_r[`VB_IRQ_FAULT] <= enter_fault;
            evt_r[`VB_IRQ_BLANK] <= blank_done;
        end
    end

    assign cfg.src_on = source_power_enable_n_oe;
    assign cfg.disch_on = internal_discharge_on;
    assign cfg.in_window = in_window;
    assign cfg.st = st_r;
    assign cfg.evt = evt_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_refuse_keeps_off: assert property (clk_en && refuse |=> !source_power_enable_n_oe)
        else $error("enable driven after refused attach");
    a_window_fault: assert property (clk_en && st_r == vbus_pkg::PP_ON && attached_ok
        && !prof_r && !in_window |=> !source_power_enable_n_oe && fault_recovery_active)
        else $error("window loss did not fault");
    a_blank_load: assert property (clk_en && blank_ld |=> blank_cnt_r == $past(cfg.t_pdo))
        else $error("blank time not loaded");
    a_lower_disch: assert property (clk_en && prof_lower && !att_fall && !enter_fault
        |=> disch_cnt_r == $past(cfg.t_pdo))
        else $error("lower profile discharge not started");
    a_detach_disch: assert property (clk_en && att_fall && cfg.disch_en && cfg.t_zero != 11'h0
        ##1 clk_en |=> internal_discharge_on)
        else $error("no discharge after detach");
    a_disch_gate: assert property (!cfg.disch_en && clk_en |=> !internal_discharge_on)
        else $error("discharge while disabled");
    a_enable_attach: assert property (clk_en && !attached_ok |=> !source_power_enable_n_oe)
        else $error("enable while not attached");
    a_supply_gate: assert property (clk_en && st_r == vbus_pkg::PP_OFF && !supply_ok
        |=> !source_power_enable_n_oe)
        else $error("enable with supply check failing");
    a_recovery_exit: assert property (clk_en && st_r == vbus_pkg::PP_FAULT
        && rec_cnt_r == 11'h0 && !att_fault |=> st_r == vbus_pkg::PP_OFF)
        else $error("fault recovery did not end");
    a_blank_end: assert property (clk_en && st_r == vbus_pkg::PP_BLANK && attached_ok
        && !prof_r && !att_fault && blank_cnt_r == 11'h0 |=> st_r == vbus_pkg::PP_ON)
        else $error("blanking did not end");
endmodule : vbus_power_path_control

// File: verilog/vbus_window_calc.sv
// Purpose: Valid window limits from nominal code and shifts
// Assumes: Sense code and nominal code share one scale
// Notes: Pure logic, division by a constant
`timescale 1ns/1ns
`include "vbus_defs.svh"
module vbus_window_calc (
    // Nominal and shifts
    input wire logic [9:0] nominal,
    input wire logic [3:0] shift_hi,
    input wire logic [3:0] shift_lo,
    // Limits
    output logic [10:0] limit_hi,
    output logic [9:0] limit_lo
);
    // Base five percent plus the extra shift, either side
    wire logic [7:0] pct_hi = `VB_PCT_DEN + `VB_BASE_PCT + 8'(shift_hi);
    wire logic [7:0] pct_lo = `VB_PCT_DEN - `VB_BASE_PCT - 8'(shift_lo);
    wire logic [17:0] prod_hi = 18'(nominal) * 18'(pct_hi);
    wire logic [17:0] prod_lo = 18'(nominal) * 18'(pct_lo);
    assign limit_hi = 11'(prod_hi / 18'(`VB_PCT_DEN));
    assign limit_lo = 10'(prod_lo / 18'(`VB_PCT_DEN));
endmodule : vbus_window_calc
